// ==== core/cpd_pkg.sv ====
package cpd_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int INST_W = 14;
    localparam int DATA_W = 8;
    localparam int IP_W = 11;
    localparam int FILE_AW = 7;
    localparam int PROG_WORDS_SMALL = 512;
    localparam int DATA_WORDS = 128;

    // ----------------------------------------------------------------
    // Instruction groups and operation codes
    // ----------------------------------------------------------------
    localparam logic [1:0] GRP_FILE = 2'h0;
    localparam logic [1:0] GRP_LIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;

    localparam logic [3:0] OP_STORE_ACC = 4'h0;
    localparam logic [3:0] OP_CLEAR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_OR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOVE = 4'h8;
    localparam logic [3:0] OP_INVERT = 4'h9;
    localparam logic [3:0] OP_INC = 4'ha;
    localparam logic [3:0] OP_ROT_RIGHT = 4'hb;
    localparam logic [3:0] OP_ROT_LEFT = 4'hc;
    localparam logic [3:0] OP_SWAP = 4'hd;

    localparam logic [INST_W-1:0] INST_NOP = 14'h0000;

    // ----------------------------------------------------------------
    // Mapped special registers and status bit positions
    // ----------------------------------------------------------------
    localparam logic [FILE_AW-1:0] SFR_INDIRECT = 7'h00;
    localparam logic [FILE_AW-1:0] SFR_IP_LOW = 7'h02;
    localparam logic [FILE_AW-1:0] SFR_STATUS = 7'h03;
    localparam logic [FILE_AW-1:0] SFR_POINTER = 7'h04;

    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [IP_W-1:0] IP_RESET = 11'h000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PHASE_ONE,
        PHASE_TWO,
        PHASE_THREE,
        PHASE_FOUR
    } cpd_phase_t;

    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } cpd_flags_t;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        cpd_flags_t flags;
        cpd_flags_t update;
    } cpd_alu_out_t;

    typedef struct packed {
        logic [1:0] group;
        logic [3:0] op;
        logic dest;
        logic [FILE_AW-1:0] file;
    } cpd_inst_t;

endpackage

// ==== core/cpd_alu.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpd_alu (
    // Operation select
    input wire logic [3:0] op,
    // Operands
    input wire logic [7:0] operand,
    input wire logic [7:0] acc,
    input wire logic carryIn,
    // Result and flags
    output cpd_pkg::cpd_alu_out_t aluOut
);

    logic [7:0] addend;
    logic addCarry;
    logic [4:0] lowSum;
    logic [8:0] fullSum;

    // ----------------------------------------------------------------
    // Adder
    // ----------------------------------------------------------------
    // Subtraction is operand plus inverted accumulator plus one, so the
    // carry outputs read high when no borrow occurs.
    always_comb begin
        addend = (op == cpd_pkg::OP_SUB) ? ~acc : acc;
        addCarry = (op == cpd_pkg::OP_SUB);
        lowSum = {1'b0, operand[3:0]} + {1'b0, addend[3:0]}
            + {4'h0, addCarry};
        fullSum = {1'b0, operand} + {1'b0, addend} + {8'h00, addCarry};
    end

    // ----------------------------------------------------------------
    // Operation and flag selection
    // ----------------------------------------------------------------
    always_comb begin
        aluOut = '0;
        aluOut.flags.c = carryIn;
        case (op)
            cpd_pkg::OP_STORE_ACC: aluOut.result = acc;
            cpd_pkg::OP_CLEAR: aluOut.result = 8'h00;
            cpd_pkg::OP_SUB, cpd_pkg::OP_ADD: begin
                aluOut.result = fullSum[7:0];
                aluOut.flags.c = fullSum[8];
                aluOut.flags.dc = lowSum[4];
                aluOut.update.c = 1'b1;
                aluOut.update.dc = 1'b1;
            end
            cpd_pkg::OP_DEC: aluOut.result = operand - 8'h01;
            cpd_pkg::OP_OR: aluOut.result = operand | acc;
            cpd_pkg::OP_AND: aluOut.result = operand & acc;
            cpd_pkg::OP_XOR: aluOut.result = operand ^ acc;
            cpd_pkg::OP_MOVE: aluOut.result = operand;
            cpd_pkg::OP_INVERT: aluOut.result = ~operand;
            cpd_pkg::OP_INC: aluOut.result = operand + 8'h01;
            cpd_pkg::OP_ROT_RIGHT: begin
                aluOut.result = {carryIn, operand[7:1]};
                aluOut.flags.c = operand[0];
                aluOut.update.c = 1'b1;
            end
            cpd_pkg::OP_ROT_LEFT: begin
                aluOut.result = {operand[6:0], carryIn};
                aluOut.flags.c = operand[7];
                aluOut.update.c = 1'b1;
            end
            cpd_pkg::OP_SWAP: aluOut.result = {operand[3:0], operand[7:4]};
            default: aluOut.result = operand;
        endcase
        // Rotates, swap and the accumulator store leave the zero flag.
        aluOut.update.z = !(op == cpd_pkg::OP_STORE_ACC
            || op == cpd_pkg::OP_SWAP || op == cpd_pkg::OP_ROT_RIGHT
            || op == cpd_pkg::OP_ROT_LEFT);
        aluOut.flags.z = (aluOut.result == 8'h00);
    end

endmodule

`default_nettype wire

// ==== core/cpd_core.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpd_core #(
    parameter int PROG_WORDS = cpd_pkg::PROG_WORDS_SMALL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Program memory load port
    input wire logic progLoadEn,
    input wire logic [cpd_pkg::IP_W-1:0] progLoadAddr,
    input wire logic [cpd_pkg::INST_W-1:0] progLoadData,
    // Observed core state
    output cpd_pkg::cpd_phase_t phase,
    output logic [cpd_pkg::IP_W-1:0] instructionPointer,
    output logic [cpd_pkg::INST_W-1:0] instructionLatch,
    output logic [cpd_pkg::DATA_W-1:0] accValue,
    output cpd_pkg::cpd_flags_t flagsValue
);

    localparam int PROG_IW = $clog2(PROG_WORDS);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Program and data live in two arrays with their own ports, so a
    // fetch never waits on a data access.
    logic [cpd_pkg::INST_W-1:0] progMem [0:PROG_WORDS-1];
    logic [cpd_pkg::DATA_W-1:0] dataMem [0:cpd_pkg::DATA_WORDS-1];

    cpd_pkg::cpd_phase_t phase_reg, phase_next;
    logic [cpd_pkg::IP_W-1:0] ip_reg, ip_next;
    logic [cpd_pkg::INST_W-1:0] fetch_reg, fetch_next;
    logic [cpd_pkg::INST_W-1:0] inst_reg, inst_next;
    logic flush_reg, flush_next;
    logic [cpd_pkg::DATA_W-1:0] operand_reg, operand_next;
    cpd_pkg::cpd_alu_out_t result_reg, result_next;
    logic [cpd_pkg::DATA_W-1:0] acc_reg, acc_next;
    logic [cpd_pkg::DATA_W-1:0] status_reg, status_next;
    logic [cpd_pkg::DATA_W-1:0] pointer_reg, pointer_next;

    cpd_pkg::cpd_inst_t inst;
    cpd_pkg::cpd_alu_out_t aluOut;
    logic [cpd_pkg::FILE_AW-1:0] effAddr;
    logic [cpd_pkg::DATA_W-1:0] readValue;
    logic [cpd_pkg::DATA_W-1:0] aluOperand;
    logic [cpd_pkg::INST_W-1:0] progWord;
    logic isFile;
    logic isLit;
    logic isJump;
    logic writesFile;
    logic writesAcc;
    logic memWriteEn;

    // ----------------------------------------------------------------
    // Decode and operand selection
    // ----------------------------------------------------------------
    always_comb begin
        inst = cpd_pkg::cpd_inst_t'(inst_reg);
        isFile = (inst.group == cpd_pkg::GRP_FILE);
        isLit = (inst.group == cpd_pkg::GRP_LIT);
        isJump = (inst.group == cpd_pkg::GRP_JUMP);
        // Address zero reaches the location named by the pointer.
        effAddr = (inst.file == cpd_pkg::SFR_INDIRECT)
            ? pointer_reg[cpd_pkg::FILE_AW-1:0] : inst.file;
        writesFile = isFile && inst.dest;
        writesAcc = isLit
            || (isFile && !inst.dest && inst.op != cpd_pkg::OP_STORE_ACC);
        aluOperand = isLit ? {inst.dest, inst.file} : operand_reg;
        progWord = progMem[ip_reg[PROG_IW-1:0]];
    end

    // Special registers answer at their own addresses; an indirect access
    // that points back at address zero reads as zero.
    always_comb begin
        case (effAddr)
            cpd_pkg::SFR_INDIRECT: readValue = 8'h00;
            cpd_pkg::SFR_IP_LOW: readValue = ip_reg[7:0];
            cpd_pkg::SFR_STATUS: readValue = status_reg;
            cpd_pkg::SFR_POINTER: readValue = pointer_reg;
            default: readValue = dataMem[effAddr];
        endcase
    end

    cpd_alu u_alu (
        .op(inst.op),
        .operand(aluOperand),
        .acc(acc_reg),
        .carryIn(status_reg[cpd_pkg::FLAG_C]),
        .aluOut(aluOut)
    );

    // ----------------------------------------------------------------
    // Phase sequencer and pipeline
    // ----------------------------------------------------------------
    always_comb begin
        phase_next = phase_reg;
        ip_next = ip_reg;
        fetch_next = fetch_reg;
        inst_next = inst_reg;
        flush_next = flush_reg;
        operand_next = operand_reg;
        result_next = result_reg;
        acc_next = acc_reg;
        status_next = status_reg;
        pointer_next = pointer_reg;
        memWriteEn = 1'b0;
        case (phase_reg)
            cpd_pkg::PHASE_ONE: begin
                phase_next = cpd_pkg::PHASE_TWO;
                // A flushed slot executes as a no-op, and the pointer
                // holds so that the branch target is fetched next.
                inst_next = flush_reg ? cpd_pkg::INST_NOP
                    : fetch_reg;
                ip_next = flush_reg ? ip_reg : ip_reg + 11'h001;
                flush_next = 1'b0;
            end
            cpd_pkg::PHASE_TWO: begin
                phase_next = cpd_pkg::PHASE_THREE;
                operand_next = readValue;
            end
            cpd_pkg::PHASE_THREE: begin
                phase_next = cpd_pkg::PHASE_FOUR;
                result_next = aluOut;
            end
            cpd_pkg::PHASE_FOUR: begin
                phase_next = cpd_pkg::PHASE_ONE;
                // This fetch runs while the current word executes.
                fetch_next = progWord;
                if (writesAcc) begin
                    acc_next = result_reg.result;
                end
                if (writesFile) begin
                    case (effAddr)
                        cpd_pkg::SFR_INDIRECT: memWriteEn = 1'b0;
                        cpd_pkg::SFR_IP_LOW: begin
                            ip_next = {ip_reg[10:8], result_reg.result};
                            flush_next = 1'b1;
                        end
                        cpd_pkg::SFR_STATUS: status_next = result_reg.result;
                        cpd_pkg::SFR_POINTER: pointer_next = result_reg.result;
                        default: memWriteEn = 1'b1;
                    endcase
                end
                if (isFile || isLit) begin
                    // Flag results win over a direct write to status.
                    if (result_reg.update.c) begin
                        status_next[cpd_pkg::FLAG_C] =
                            result_reg.flags.c;
                    end
                    if (result_reg.update.dc) begin
                        status_next[cpd_pkg::FLAG_DC] =
                            result_reg.flags.dc;
                    end
                    if (result_reg.update.z) begin
                        status_next[cpd_pkg::FLAG_Z] =
                            result_reg.flags.z;
                    end
                end
                if (isJump) begin
                    ip_next = inst_reg[cpd_pkg::IP_W-1:0];
                    flush_next = 1'b1;
                end
            end
            default: phase_next = cpd_pkg::PHASE_ONE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_reg <= cpd_pkg::PHASE_ONE;
            ip_reg <= cpd_pkg::IP_RESET;
            fetch_reg <= cpd_pkg::INST_NOP;
            inst_reg <= cpd_pkg::INST_NOP;
            flush_reg <= 1'b1;
            operand_reg <= '0;
            result_reg <= '0;
            acc_reg <= cpd_pkg::ACC_RESET;
            status_reg <= cpd_pkg::STATUS_RESET;
            pointer_reg <= cpd_pkg::POINTER_RESET;
        end else begin
            phase_reg <= phase_next;
            ip_reg <= ip_next;
            fetch_reg <= fetch_next;
            inst_reg <= inst_next;
            flush_reg <= flush_next;
            operand_reg <= operand_next;
            result_reg <= result_next;
            acc_reg <= acc_next;
            status_reg <= status_next;
            pointer_reg <= pointer_next;
        end
    end

    // ----------------------------------------------------------------
    // Memory write ports
    // ----------------------------------------------------------------
    // The load port only fills the program image; the core itself never
    // writes program memory.
    always_ff @(posedge clk) begin
        if (progLoadEn) begin
            progMem[progLoadAddr[PROG_IW-1:0]] <= progLoadData;
        end
        if (memWriteEn) begin
            dataMem[effAddr] <= result_reg.result;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign phase = phase_reg;
    assign instructionPointer = ip_reg;
    assign instructionLatch = inst_reg;
    assign accValue = acc_reg;
    assign flagsValue = cpd_pkg::cpd_flags_t'(status_reg[2:0]);

endmodule

`default_nettype wire

// ==== verif/cpd_core_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpd_core_checker #(
    parameter int PROG_WORDS = cpd_pkg::PROG_WORDS_SMALL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Program load port
    input wire logic progLoadEn,
    input wire logic [cpd_pkg::IP_W-1:0] progLoadAddr,
    input wire logic [cpd_pkg::INST_W-1:0] progLoadData,
    // Core state
    input wire cpd_pkg::cpd_phase_t phase,
    input wire logic [cpd_pkg::IP_W-1:0] instructionPointer,
    input wire logic [cpd_pkg::INST_W-1:0] instructionLatch,
    input wire logic [cpd_pkg::DATA_W-1:0] accValue,
    input wire cpd_pkg::cpd_flags_t flagsValue
);
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    // The mask lets a step past the last word wrap or not.
    localparam logic [10:0] IP_MASK = 11'(PROG_WORDS - 1);
    logic [10:0] jumpTarget_reg;
    logic [10:0] jumpTarget_next;
    logic jumpNow;
    logic ipWrite;

    assign jumpNow = phase == cpd_pkg::PHASE_TWO &&
        instructionLatch[13:12] == cpd_pkg::GRP_JUMP;

    // A write that may reach the low pointer byte is a branch as well.
    assign ipWrite = instructionLatch[13:12] == cpd_pkg::GRP_FILE &&
        instructionLatch[7] &&
        (instructionLatch[6:0] == cpd_pkg::SFR_IP_LOW ||
        instructionLatch[6:0] == cpd_pkg::SFR_INDIRECT);

    always_comb begin
        jumpTarget_next = jumpTarget_reg;
        if (jumpNow) begin
            jumpTarget_next = instructionLatch[10:0];
        end
    end

    always_ff @(posedge clk) begin
        jumpTarget_reg <= jumpTarget_next;
    end

    // ----------------------------------------------------------------
    // Sequences and assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence quarterWalk;
        phase == cpd_pkg::PHASE_TWO ##1 phase == cpd_pkg::PHASE_THREE
            ##1 phase == cpd_pkg::PHASE_FOUR ##1 phase == cpd_pkg::PHASE_ONE;
    endsequence

    sequence releaseFlush;
        (instructionPointer == 11'h000 &&
            instructionLatch == cpd_pkg::INST_NOP)[*5]
            ##1 instructionPointer == 11'h001;
    endsequence

    sequence jumpFlush;
        ##4 instructionLatch == cpd_pkg::INST_NOP
            ##4 instructionPointer == jumpTarget_reg + 11'h001;
    endsequence

    // The sampled reset keeps the edge that releases reset out of the walk.
    a_phase_cycle: assert property (
        phase == cpd_pkg::PHASE_ONE && !reset |=> quarterWalk)
        else $error("phase sequence broken");
    a_reset_state: assert property (disable iff (1'b0)
        reset |=> phase == cpd_pkg::PHASE_ONE &&
        instructionPointer == 11'h000 && instructionLatch == 14'h0000 &&
        accValue == 8'h00 && flagsValue == 3'h0)
        else $error("reset state wrong");
    a_release_flush: assert property (
        $fell(reset) |-> releaseFlush)
        else $error("first cycle after reset not flushed");
    a_latch_timing: assert property (
        $changed(instructionLatch) |-> phase == cpd_pkg::PHASE_TWO)
        else $error("latch loaded outside phase one");
    a_write_timing: assert property (
        $changed(accValue) || $changed(flagsValue)
        |-> phase == cpd_pkg::PHASE_ONE)
        else $error("result written outside phase four");
    a_pointer_step: assert property (
        $changed(instructionPointer) && phase == cpd_pkg::PHASE_TWO
        |-> ((instructionPointer - $past(instructionPointer) - 11'h001)
        & IP_MASK) == 11'h000)
        else $error("pointer step in phase one is not one");
    a_branch_flush: assert property (
        jumpNow |-> jumpFlush)
        else $error("jump not followed by flush and target");
    a_single_cycle: assert property (
        phase == cpd_pkg::PHASE_TWO && !jumpNow && !ipWrite &&
        instructionLatch != cpd_pkg::INST_NOP |-> ##4
        ((instructionPointer - $past(instructionPointer, 4) - 11'h001)
        & IP_MASK) == 11'h000)
        else $error("plain instruction took more than one cycle");
endmodule

bind cpd_core cpd_core_checker #(.PROG_WORDS(PROG_WORDS)) cpd_core_checker_i (
    .clk(clk), .reset(reset), .progLoadEn(progLoadEn),
    .progLoadAddr(progLoadAddr), .progLoadData(progLoadData), .phase(phase),
    .instructionPointer(instructionPointer),
    .instructionLatch(instructionLatch), .accValue(accValue),
    .flagsValue(flagsValue));

`default_nettype wire

// ==== verif/cpd_prog_loader.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpd_prog_loader #(
    parameter int PROG_WORDS = cpd_pkg::PROG_WORDS_SMALL
) (
    // Clock
    input wire logic clk,
    // Program load port
    output logic progLoadEn,
    output logic [cpd_pkg::IP_W-1:0] progLoadAddr,
    output logic [cpd_pkg::INST_W-1:0] progLoadData
);
    initial begin
        progLoadEn = 1'b0;
        progLoadAddr = 11'h000;
        progLoadData = 14'h0000;
    end

    // Whole 14-bit words, addresses kept inside the on-chip array.
    task put(input logic [10:0] a, input logic [13:0] d);
        @(posedge clk);
        progLoadEn <= 1'b1;
        progLoadAddr <= a & 11'(PROG_WORDS - 1);
        progLoadData <= d;
    endtask

    // Released lines do not keep the last word, so a stale read shows.
    task idle();
        @(posedge clk);
        progLoadEn <= 1'b0;
        progLoadAddr <= ~progLoadAddr;
        progLoadData <= ~progLoadData;
    endtask
endmodule

`default_nettype wire

// ==== verif/cpu_core_datapath_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_core_datapath_bench;
    localparam int PROG_WORDS = cpd_pkg::PROG_WORDS_SMALL;
    localparam int TIME_LIMIT = 3000;
    logic clk;
    logic reset;
    logic progLoadEn;
    logic [10:0] progLoadAddr;
    logic [13:0] progLoadData;
    cpd_pkg::cpd_phase_t phase;
    logic [10:0] instructionPointer;
    logic [13:0] instructionLatch;
    logic [7:0] accValue;
    cpd_pkg::cpd_flags_t flagsValue;
    int errorCnt = 0;
    int numChecks = 0;
    int cycleCount = 0;
    logic [10:0] progAddr[$];
    logic [13:0] progWord[$];

    cpd_core #(.PROG_WORDS(PROG_WORDS)) cpd_core_i (.clk(clk),
        .reset(reset), .progLoadEn(progLoadEn), .progLoadAddr(progLoadAddr),
        .progLoadData(progLoadData), .phase(phase),
        .instructionPointer(instructionPointer),
        .instructionLatch(instructionLatch), .accValue(accValue),
        .flagsValue(flagsValue));
    cpd_prog_loader #(.PROG_WORDS(PROG_WORDS)) cpd_prog_loader_i (.clk(clk),
        .progLoadEn(progLoadEn), .progLoadAddr(progLoadAddr),
        .progLoadData(progLoadData));

    initial clk = 1'b0;
    always #20 clk = ~clk;

    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == TIME_LIMIT) begin
            errorCnt++;
            testDone();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [13:0] lit(logic [3:0] op, logic [7:0] v);
        return {cpd_pkg::GRP_LIT, op, v};
    endfunction
    function automatic logic [13:0] fop(logic [3:0] op, logic d,
        logic [6:0] f);
        return {cpd_pkg::GRP_FILE, op, d, f};
    endfunction
    function automatic logic [13:0] jmp(logic [10:0] a);
        return {cpd_pkg::GRP_JUMP, 1'b0, a};
    endfunction

    task word(input logic [10:0] a, input logic [13:0] w);
        progAddr.push_back(a);
        progWord.push_back(w);
    endtask

    // Loads under reset, so every run after the first also covers a reset in mid-run.
    task runProg(input int nInst);
        @(posedge clk);
        reset <= 1'b1;
        foreach (progAddr[k]) cpd_prog_loader_i.put(progAddr[k], progWord[k]);
        cpd_prog_loader_i.idle();
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4 * nInst + 8) @(posedge clk);
        #1;
        progAddr.delete();
        progWord.delete();
    endtask

    task checkAcc(input string what, input logic [7:0] expV);
        numChecks++;
        if (accValue !== expV) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", what, expV,
                accValue);
        end
    endtask

    task checkFlags(input string what, input cpd_pkg::cpd_flags_t expV);
        numChecks++;
        if (flagsValue !== expV) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", what, expV,
                flagsValue);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task scenCarry();
        word(11'h000, jmp(11'h1fd));
        word(11'h1fd, lit(cpd_pkg::OP_MOVE, 8'h8f));
        word(11'h1fe, lit(cpd_pkg::OP_ADD, 8'h71));
        word(11'h1ff, jmp(11'h005));
        word(11'h005, jmp(11'h005));
        runProg(10);
        checkAcc("wrapped sum", 8'h00);
        checkFlags("sum flags", 3'h7);
    endtask

    task scenBorrow();
        word(11'h000, lit(cpd_pkg::OP_MOVE, 8'h10));
        word(11'h001, lit(cpd_pkg::OP_SUB, 8'h01));
        word(11'h002, fop(cpd_pkg::OP_MOVE, 1'b0, cpd_pkg::SFR_STATUS));
        word(11'h003, jmp(11'h003));
        runProg(6);
        checkAcc("status read", 8'h02);
        checkFlags("flags after read", 3'h2);
    endtask

    task scenIndirect();
        word(11'h000, lit(cpd_pkg::OP_MOVE, 8'hd5));
        word(11'h001, fop(cpd_pkg::OP_STORE_ACC, 1'b1, 7'h20));
        word(11'h002, lit(cpd_pkg::OP_MOVE, 8'h20));
        word(11'h003, fop(cpd_pkg::OP_STORE_ACC, 1'b1, cpd_pkg::SFR_POINTER));
        word(11'h004, lit(cpd_pkg::OP_MOVE, 8'h00));
        word(11'h005, fop(cpd_pkg::OP_MOVE, 1'b0, cpd_pkg::SFR_INDIRECT));
        word(11'h006, fop(cpd_pkg::OP_ROT_LEFT, 1'b0, 7'h20));
        word(11'h007, jmp(11'h007));
        runProg(10);
        checkAcc("rotated file", 8'haa);
        checkFlags("rotate flags", 3'h1);
    endtask

    // The word after the pointer write must be flushed, else 0x11 joins
    // the sum.
    task scenComputed();
        word(11'h000, lit(cpd_pkg::OP_MOVE, 8'h06));
        word(11'h001, fop(cpd_pkg::OP_STORE_ACC, 1'b1, cpd_pkg::SFR_IP_LOW));
        word(11'h002, lit(cpd_pkg::OP_MOVE, 8'h11));
        word(11'h006, fop(cpd_pkg::OP_ADD, 1'b0, cpd_pkg::SFR_IP_LOW));
        word(11'h007, jmp(11'h007));
        runProg(8);
        checkAcc("computed jump sum", 8'h0d);
        checkFlags("computed jump flags", 3'h0);
    endtask

    task scenLiteral();
        logic [3:0] ops[11];
        logic [8:0] r;
        logic dc;
        ops = '{cpd_pkg::OP_OR, cpd_pkg::OP_AND, cpd_pkg::OP_XOR,
            cpd_pkg::OP_ADD, cpd_pkg::OP_CLEAR, cpd_pkg::OP_DEC,
            cpd_pkg::OP_INVERT, cpd_pkg::OP_INC, cpd_pkg::OP_ROT_RIGHT,
            cpd_pkg::OP_SWAP, cpd_pkg::OP_SUB};
        foreach (ops[i]) begin
            dc = 1'b0;
            case (ops[i])
                cpd_pkg::OP_OR: r = {1'b0, 8'h3c | 8'ha5};
                cpd_pkg::OP_AND: r = {1'b0, 8'h3c & 8'ha5};
                cpd_pkg::OP_XOR: r = {1'b0, 8'h3c ^ 8'ha5};
                cpd_pkg::OP_ADD: begin
                    r = 9'h03c + 9'h0a5;
                    dc = 1'b1;
                end
                cpd_pkg::OP_CLEAR: r = 9'h000;
                cpd_pkg::OP_DEC: r = {1'b0, 8'ha5 - 8'h01};
                cpd_pkg::OP_INVERT: r = {1'b0, ~8'ha5};
                cpd_pkg::OP_INC: r = {1'b0, 8'ha5 + 8'h01};
                // Carry enters as zero and bit 0 leaves as carry.
                cpd_pkg::OP_ROT_RIGHT: r = 9'h152;
                cpd_pkg::OP_SWAP: r = 9'h05a;
                default: r = {1'b1, 8'ha5 - 8'h3c};
            endcase
            word(11'h000, lit(cpd_pkg::OP_MOVE, 8'h3c));
            word(11'h001, lit(ops[i], 8'ha5));
            word(11'h002, jmp(11'h002));
            runProg(5);
            checkAcc("literal result", r[7:0]);
            checkFlags("lit flags", {r[7:0] == 8'h00, dc, r[8]});
        end
    endtask

    task testDone();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        repeat (5) @(posedge clk);
        scenCarry();
        scenBorrow();
        scenIndirect();
        scenComputed();
        scenLiteral();
        testDone();
    end
endmodule

`default_nettype wire
